// ### core/mct_pkg.sv
// ----------------------------------------------------------------
// shared constants and carriers of the command / transmit bank
// ----------------------------------------------------------------
package mct_pkg;

    // ------------------------------------------------------------
    // register offsets, page 0 (command sits in every page)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_COMMAND_CONTROL = 5'h00;
    localparam logic [4:0] OFS_RX_RING_FIRST_PAGE = 5'h01;
    localparam logic [4:0] OFS_RX_RING_LAST_PAGE = 5'h02;
    localparam logic [4:0] OFS_RX_RING_BOUNDARY = 5'h03;
    localparam logic [4:0] OFS_TX_PAGE_AND_FLAGS = 5'h04;
    localparam logic [4:0] OFS_TX_LENGTH_LOW = 5'h05;
    localparam logic [4:0] OFS_TX_LENGTH_HIGH = 5'h06;

    // ------------------------------------------------------------
    // page selection codes
    // ------------------------------------------------------------
    localparam logic [1:0] PAGE_0 = 2'h0;
    localparam logic [1:0] PAGE_1 = 2'h1;
    localparam logic [1:0] PAGE_2 = 2'h2;
    localparam logic [1:0] PAGE_3 = 2'h3;

    // ------------------------------------------------------------
    // remote dma command codes
    // ------------------------------------------------------------
    localparam logic [2:0] DMA_BAD_LOW = 3'h0;
    localparam logic [2:0] DMA_READ = 3'h1;
    localparam logic [2:0] DMA_WRITE = 3'h2;
    localparam logic [2:0] DMA_BAD_HIGH = 3'h3;
    localparam logic [2:0] DMA_ABORT = 3'h4;
    localparam int DMA_ABORT_BIT = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_COMMAND_CONTROL = 8'h21;
    localparam logic [7:0] RST_RX_RING_FIRST_PAGE = 8'h00;
    localparam logic [7:0] RST_RX_RING_LAST_PAGE = 8'h00;
    localparam logic [7:0] RST_RX_RING_BOUNDARY = 8'h4C;
    localparam logic [7:0] RST_TX_RESULT_FLAGS = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // ------------------------------------------------------------
    // flag positions of the transmit result byte
    // ------------------------------------------------------------
    localparam int POS_LATE_CLASH_FLAG = 7;
    localparam int POS_TX_GAVE_UP_FLAG = 3;
    localparam int POS_TX_COLLIDED_FLAG = 2;
    localparam int POS_TX_OK_FLAG = 0;

    // command byte: page 7:6, dma 5:3, trigger 2, start 1, stop 0
    typedef struct packed {
        logic [1:0] page_select_bits;
        logic [2:0] dma_code;
        logic send_frame_trigger;
        logic run;
        logic stop;
    } mct_cmd_t;

    // outcome of one transmission, from the transmit path
    typedef struct packed {
        logic late_clash_flag;
        logic tx_gave_up_flag;
        logic collided;
        logic tx_ok_flag;
        logic [3:0] retry_tally;
    } mct_tx_result_t;

endpackage : mct_pkg

// ### core/mct_cmd_tx_regs.sv
// Operation
// [RL1] command bits 7:6 pick register page 0..3, page 0 after reset.
// [RL2] command resets to 21h and page, dma and stop fields return to default on sleep entry.
// [RL3] dma code 001 is remote read, 010 remote write, 000/011 forbidden, 1xx abort or complete.
// [RL4] host may set the dma top bit to abort, and the device sets it when a transfer finishes.
// [RL5] after an abort the host clears the remote byte count before a new dma command.
// [RL6] an abort leaves the working remote address where it stopped, no reload of the start.
// [RL7] writing one to command bit 2 launches the frame given by tx first page and tx length.
// [RL8] command bit 1 reads one once set and only hardware or software reset clears it.
// [RL9] writing command bit 0 high halts operation and it returns to default on sleep entry.
// [RL10] page 0 offsets 01h and 02h hold read/write ring first and last page, reset 00h.
// [RL11] page 0 offset 03h holds the read/write ring boundary page, reset 4Ch.
// [RL12] page 0 offset 04h takes the tx first page on writes and returns tx flags on reads.
// [RL13] tx flags reset to 00h, bit 7 late clash, bit 3 gave up, bits 6:4 and 1 reserved.
// [RL14] tx flag bit 2 means at least one collision and bit 0 means sent without error.
// [RL15] tx length is 16 bits, low byte at offset 05h, high byte at offset 06h.
// [RL16] retry tally at offset 05h clears on a trigger write and is zero without collisions; a result landing with that write loads its tally instead.
// [RL17] a forbidden dma code starts nothing and keeps the dma engine idle.
`timescale 1ns/10ps
module mct_cmd_tx_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // host register port
    input wire logic host_cs,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // power and software reset events
    input wire logic sleep_enter,
    input wire logic soft_reset,
    // remote dma engine
    input wire logic dma_done,
    output logic dma_read_go,
    output logic dma_write_go,
    output logic dma_abort,
    // transmit path
    input wire logic tx_done,
    input wire mct_pkg::mct_tx_result_t tx_result,
    output logic tx_go,
    output logic [7:0] tx_buffer_first_page,
    output logic [15:0] tx_length,
    // receive ring and operating state
    output logic [7:0] rx_ring_first_page,
    output logic [7:0] rx_ring_last_page,
    output logic [7:0] rx_ring_boundary,
    output logic [1:0] page_select_bits,
    output logic run_active,
    output logic halted
);
    import mct_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n_q;

    // release through two stages; assertion is asynchronous
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_q <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    mct_cmd_t command_control;
    mct_cmd_t wr_cmd;
    logic [7:0] tx_result_flags;
    logic [3:0] retry_tally;
    logic [7:0] tx_length_low;
    logic [7:0] tx_length_high;

    wire wr_en = host_cs & host_wr;
    wire rd_en = host_cs & host_rd;
    wire pg0 = (command_control.page_select_bits == PAGE_0); // RL1
    wire hit_cmd = (host_addr == OFS_COMMAND_CONTROL);
    wire hit_first = pg0 & (host_addr == OFS_RX_RING_FIRST_PAGE); // RL10
    wire hit_last = pg0 & (host_addr == OFS_RX_RING_LAST_PAGE); // RL10
    wire hit_bnd = pg0 & (host_addr == OFS_RX_RING_BOUNDARY); // RL11
    wire hit_txpg = pg0 & (host_addr == OFS_TX_PAGE_AND_FLAGS); // RL12
    wire hit_lenl = pg0 & (host_addr == OFS_TX_LENGTH_LOW); // RL15
    wire hit_lenh = pg0 & (host_addr == OFS_TX_LENGTH_HIGH); // RL15
    wire wr_cmd_en = wr_en & hit_cmd;

    // ------------------------------------------------------------
    // command register next value
    // ------------------------------------------------------------
    assign wr_cmd = mct_cmd_t'(host_wdata);
    wire mct_cmd_t cmd_rst = mct_cmd_t'(RST_COMMAND_CONTROL);
    wire dma_busy = ~command_control.dma_code[DMA_ABORT_BIT];
    // forbidden codes are swallowed and the engine stays idle
    wire code_ok = (wr_cmd.dma_code != DMA_BAD_LOW) & (wr_cmd.dma_code != DMA_BAD_HIGH); // RL3 RL17
    wire go_read = wr_cmd_en & (wr_cmd.dma_code == DMA_READ); // RL3
    wire go_write = wr_cmd_en & (wr_cmd.dma_code == DMA_WRITE); // RL3
    wire go_abort = wr_cmd_en & wr_cmd.dma_code[DMA_ABORT_BIT] & dma_busy; // RL4
    wire trig_wr = wr_cmd_en & wr_cmd.send_frame_trigger; // RL7
    wire [2:0] code_w = code_ok ? wr_cmd.dma_code : DMA_ABORT; // RL17
    // completion sets the top bit; set wins over a host write
    wire [2:0] code_d = dma_done ? (code_w | DMA_ABORT) : code_w; // RL4
    wire [2:0] code_h = dma_done ? (command_control.dma_code | DMA_ABORT)
                                 : command_control.dma_code; // RL4

    mct_cmd_t next_cmd;
    always_comb begin
        next_cmd = command_control;
        next_cmd.dma_code = code_h;
        if (wr_cmd_en) begin
            next_cmd.page_select_bits = wr_cmd.page_select_bits; // RL1
            next_cmd.dma_code = code_d; // RL3
            next_cmd.stop = wr_cmd.stop; // RL9
            next_cmd.run = command_control.run | wr_cmd.run; // RL8
        end
        // trigger reads back one until the frame has gone
        if (tx_done) begin
            next_cmd.send_frame_trigger = 1'b0;
        end
        if (trig_wr) begin
            next_cmd.send_frame_trigger = 1'b1; // RL7
        end
        // sleep entry restores page, dma and stop fields only
        if (sleep_enter) begin
            next_cmd.page_select_bits = cmd_rst.page_select_bits; // RL2
            next_cmd.dma_code = cmd_rst.dma_code; // RL2
            next_cmd.stop = cmd_rst.stop; // RL2 RL9
        end
        if (soft_reset) begin
            next_cmd = cmd_rst; // RL8
        end
    end

    // command register and dma strobes
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            command_control <= mct_cmd_t'(RST_COMMAND_CONTROL); // RL2
            dma_read_go <= 1'b0;
            dma_write_go <= 1'b0;
            dma_abort <= 1'b0;
            tx_go <= 1'b0;
        end else begin
            command_control <= next_cmd;
            dma_read_go <= go_read & ~sleep_enter & ~soft_reset;
            dma_write_go <= go_write & ~sleep_enter & ~soft_reset;
            // the engine keeps its working address on abort
            dma_abort <= go_abort | (dma_busy & (sleep_enter | soft_reset)); // RL6
            tx_go <= trig_wr & ~soft_reset; // RL7
        end
    end

    // ------------------------------------------------------------
    // ring and transmit setup registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_ring_first_page <= RST_RX_RING_FIRST_PAGE;
            rx_ring_last_page <= RST_RX_RING_LAST_PAGE;
            rx_ring_boundary <= RST_RX_RING_BOUNDARY;
            tx_buffer_first_page <= RST_ZERO;
            tx_length_low <= RST_ZERO;
            tx_length_high <= RST_ZERO;
        end else if (wr_en) begin
            if (hit_first) begin
                rx_ring_first_page <= host_wdata; // RL10
            end
            if (hit_last) begin
                rx_ring_last_page <= host_wdata; // RL10
            end
            if (hit_bnd) begin
                rx_ring_boundary <= host_wdata; // RL11
            end
            if (hit_txpg) begin
                tx_buffer_first_page <= host_wdata; // RL12
            end
            if (hit_lenl) begin
                tx_length_low <= host_wdata; // RL15
            end
            if (hit_lenh) begin
                tx_length_high <= host_wdata; // RL15
            end
        end
    end

    // ------------------------------------------------------------
    // transmit result capture
    // ------------------------------------------------------------
    // a gave-up frame reports a zero tally whatever the path says
    wire [7:0] flags_in = {tx_result.late_clash_flag, 3'h0, tx_result.tx_gave_up_flag,
                           tx_result.collided, 1'b0, tx_result.tx_ok_flag}; // RL13 RL14
    wire [3:0] tally_in = (tx_result.tx_gave_up_flag | ~tx_result.collided)
                          ? 4'h0 : tx_result.retry_tally; // RL16

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_result_flags <= RST_TX_RESULT_FLAGS; // RL13
            retry_tally <= 4'h0;
        end else begin
            if (tx_done) begin
                tx_result_flags <= flags_in; // RL13 RL14
            end
            // a result landing with the trigger write wins
            if (tx_done) begin
                retry_tally <= tally_in; // RL16
            end else if (trig_wr) begin
                retry_tally <= 4'h0; // RL16
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire [7:0] rd_mux = hit_cmd ? command_control :
                        hit_first ? rx_ring_first_page :
                        hit_last ? rx_ring_last_page :
                        hit_bnd ? rx_ring_boundary :
                        hit_txpg ? tx_result_flags : // RL12
                        hit_lenl ? {4'h0, retry_tally} : // RL16
                        RST_ZERO;

    // read data holds until the next read strobe
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            host_rdata <= RST_ZERO;
        end else if (rd_en) begin
            host_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // registered views of the operating state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            page_select_bits <= PAGE_0;
            run_active <= 1'b0;
            halted <= 1'b1;
        end else begin
            page_select_bits <= next_cmd.page_select_bits; // RL1
            run_active <= next_cmd.run; // RL8
            halted <= next_cmd.stop; // RL9
        end
    end

    assign tx_length = {tx_length_high, tx_length_low}; // RL15

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_page_follows_write;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (wr_cmd_en & ~sleep_enter & ~soft_reset)
            |=> (page_select_bits == $past(host_wdata[7:6]));
    endproperty
    a_page_follows_write: assert property (p_page_follows_write) // RL1
        else $error("page select did not follow command write");

    property p_sleep_defaults;
        @(posedge clk_sys) disable iff (!rst_n_q)
        sleep_enter |=> (command_control.page_select_bits == PAGE_0)
            && (command_control.dma_code == DMA_ABORT) && command_control.stop;
    endproperty
    a_sleep_defaults: assert property (p_sleep_defaults) // RL2
        else $error("sleep entry left command fields off default");

    property p_read_go;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (wr_cmd_en & (host_wdata[5:3] == DMA_READ) & ~sleep_enter & ~soft_reset)
            |=> dma_read_go && !dma_write_go;
    endproperty
    a_read_go: assert property (p_read_go) // RL3
        else $error("remote read code did not start a read");

    property p_done_sets_top;
        @(posedge clk_sys) disable iff (!rst_n_q)
        dma_done |=> command_control.dma_code[DMA_ABORT_BIT];
    endproperty
    a_done_sets_top: assert property (p_done_sets_top) // RL4
        else $error("dma completion did not set top bit");

    property p_abort_pulse;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (wr_cmd_en & host_wdata[5] & dma_busy) |=> dma_abort ##1 !dma_abort[*1];
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) // RL6
        else $error("abort write did not give a one-cycle abort");

    property p_tx_go_pulse;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (trig_wr & ~soft_reset) |=> tx_go && command_control.send_frame_trigger;
    endproperty
    a_tx_go_pulse: assert property (p_tx_go_pulse) // RL7
        else $error("trigger write did not launch the frame");

    property p_run_sticky;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (run_active && !soft_reset) |=> run_active;
    endproperty
    a_run_sticky: assert property (p_run_sticky) // RL8
        else $error("run bit dropped without a reset");

    property p_boundary_write;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (wr_en & hit_bnd) |=> (rx_ring_boundary == $past(host_wdata));
    endproperty
    a_boundary_write: assert property (p_boundary_write) // RL11
        else $error("boundary page did not take the write");

    property p_flags_read;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (rd_en & hit_txpg) |=> (host_rdata == $past(tx_result_flags))
            && (host_rdata[6:4] == 3'h0) && !host_rdata[1];
    endproperty
    a_flags_read: assert property (p_flags_read) // RL12 RL13
        else $error("flag read returned wrong value");

    property p_tally_clear;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (trig_wr & ~tx_done) |=> (retry_tally == 4'h0);
    endproperty
    a_tally_clear: assert property (p_tally_clear) // RL16
        else $error("retry tally not cleared by trigger");

    property p_bad_code_idle;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (wr_cmd_en & ~code_ok) |=> !dma_read_go && !dma_write_go
            && command_control.dma_code[DMA_ABORT_BIT];
    endproperty
    a_bad_code_idle: assert property (p_bad_code_idle) // RL17
        else $error("forbidden dma code started a transfer");

endmodule : mct_cmd_tx_regs

// ### bench/mct_far_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// dma engine and transmit path standing behind the bank
// ----------------------------------------------------------------
module mct_far_model #(
    parameter int LAT = 12
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // requests from the bank
    input wire logic dma_read_go,
    input wire logic dma_write_go,
    input wire logic dma_abort,
    input wire logic tx_go,
    // bench control
    input wire logic stall,
    input wire mct_pkg::mct_tx_result_t res_in,
    // answers to the bank, busy to the bench
    output logic dma_done,
    output logic tx_done,
    output mct_pkg::mct_tx_result_t tx_result,
    output logic busy
);
    import mct_pkg::*;
    int dma_left;
    int tx_left;
    // a stalled transfer never ends by itself, only an abort ends it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dma_left <= 0;
            tx_left <= 0;
            dma_done <= 1'b0;
            tx_done <= 1'b0;
            tx_result <= '0;
        end else begin
            dma_done <= (dma_left == 1) && !stall;
            tx_done <= (tx_left == 1);
            // result is garbage outside the done cycle
            tx_result <= (tx_left == 1) ? res_in : ~res_in;
            if (dma_read_go || dma_write_go) begin
                dma_left <= LAT;
            end else if (dma_abort) begin
                dma_left <= 0;
            end else if (dma_left > 1 || (dma_left == 1 && !stall)) begin
                dma_left <= dma_left - 1;
            end
            if (tx_go) begin
                tx_left <= LAT;
            end else if (tx_left > 0) begin
                tx_left <= tx_left - 1;
            end
        end
    end
    // busy covers the done cycle so that the bench waits past it
    assign busy = (dma_left != 0) || (tx_left != 0) || dma_done || tx_done;
endmodule : mct_far_model

// ### bench/mct_cmd_tx_regs_bench.sv
`timescale 1ns/10ps
module mct_cmd_tx_regs_bench;
    import mct_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic host_cs = 1'b0;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [4:0] host_addr = 5'h00;
    logic [7:0] host_wdata = 8'h00;
    logic sleep_enter = 1'b0;
    logic soft_reset = 1'b0;
    logic stall = 1'b0;
    mct_tx_result_t res_in = '0;
    mct_tx_result_t tx_result;
    logic [7:0] host_rdata, tx_buffer_first_page, rx_first, rx_last, rx_bnd;
    logic [15:0] tx_length;
    logic [1:0] page_select_bits;
    logic dma_done, dma_read_go, dma_write_go, dma_abort, tx_done, tx_go;
    logic run_active, halted, busy;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int n_dr = 0;
    int n_dw = 0;
    int n_ab = 0;
    int n_tx = 0;
    localparam logic [7:0] RST_TAB [7] = '{8'h21, 8'h00, 8'h00, 8'h4C, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] RES_TAB [3] = '{8'h33, 8'h6F, 8'h85};

    mct_cmd_tx_regs i_mct_cmd_tx_regs (.clk_sys(clk_sys), .rstn(rstn), .host_cs(host_cs),
        .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .sleep_enter(sleep_enter), .soft_reset(soft_reset),
        .dma_done(dma_done), .dma_read_go(dma_read_go), .dma_write_go(dma_write_go),
        .dma_abort(dma_abort), .tx_done(tx_done), .tx_result(tx_result), .tx_go(tx_go),
        .tx_buffer_first_page(tx_buffer_first_page), .tx_length(tx_length),
        .rx_ring_first_page(rx_first), .rx_ring_last_page(rx_last),
        .rx_ring_boundary(rx_bnd), .page_select_bits(page_select_bits),
        .run_active(run_active), .halted(halted));
    mct_far_model i_mct_far_model (.clk_sys(clk_sys), .rstn(rstn), .dma_read_go(dma_read_go),
        .dma_write_go(dma_write_go), .dma_abort(dma_abort), .tx_go(tx_go), .stall(stall),
        .res_in(res_in), .dma_done(dma_done), .tx_done(tx_done), .tx_result(tx_result),
        .busy(busy));

    // ------------------------------------------------------------
    // clock, pulse counters and hang guard
    // ------------------------------------------------------------
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (dma_read_go === 1'b1) n_dr++;
        if (dma_write_go === 1'b1) n_dw++;
        if (dma_abort === 1'b1) n_ab++;
        if (tx_go === 1'b1) n_tx++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // bus tasks; one idle edge between accesses
    // ------------------------------------------------------------
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        host_cs = 1'b1;
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(negedge clk_sys);
        host_cs = 1'b0;
        host_wr = 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        host_cs = 1'b1;
        host_rd = 1'b1;
        host_addr = a;
        @(negedge clk_sys);
        host_cs = 1'b0;
        host_rd = 1'b0;
        chk_val({8'h00, host_rdata}, {8'h00, e});
    endtask : rd_chk
    task automatic pulse(input logic sleep);
        @(negedge clk_sys);
        if (sleep) sleep_enter = 1'b1;
        else soft_reset = 1'b1;
        @(negedge clk_sys);
        sleep_enter = 1'b0;
        soft_reset = 1'b0;
    endtask : pulse
    // bounded wait until the far side has gone quiet
    task automatic wait_idle();
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_sys);
        chk_val({15'h0, busy}, 16'h0);
    endtask : wait_idle
    task automatic complete_run();
        if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < 7; i++) rd_chk(5'(i), RST_TAB[i]);
        chk_val({14'h0, page_select_bits, run_active, halted}, 16'h0001);
        wr(5'h01, 8'h3A);
        wr(5'h02, 8'h7F);
        wr(5'h03, 8'hC5);
        rd_chk(5'h01, 8'h3A);
        rd_chk(5'h02, 8'h7F);
        rd_chk(5'h03, 8'hC5);
        chk_val({rx_first, rx_last}, 16'h3A7F);
        chk_val({8'h00, rx_bnd}, 16'h00C5);
        // tx setup; offset 04 reads flags, not the page written
        wr(5'h04, 8'h5A);
        wr(5'h05, 8'h34);
        wr(5'h06, 8'h12);
        rd_chk(5'h04, 8'h00);
        chk_val({8'h00, tx_buffer_first_page}, 16'h005A);
        chk_val(tx_length, 16'h1234);
        // forbidden codes 000 and 011 start nothing
        wr(5'h00, 8'h02);
        rd_chk(5'h00, 8'h22);
        wr(5'h00, 8'h1A);
        rd_chk(5'h00, 8'h22);
        chk_val(16'(n_dr + n_dw), 16'h0);
        // remote read then write, each completed by the engine
        wr(5'h00, 8'h0A);
        rd_chk(5'h00, 8'h0A);
        chk_val(16'(n_dr), 16'h1);
        wait_idle();
        // completion sets only the top code bit, read code 001 becomes 101
        rd_chk(5'h00, 8'h2A);
        wr(5'h00, 8'h12);
        rd_chk(5'h00, 8'h12);
        chk_val(16'(n_dw), 16'h1);
        wait_idle();
        rd_chk(5'h00, 8'h32);
        // abort of a transfer that would never end
        stall = 1'b1;
        wr(5'h00, 8'h0A);
        wr(5'h00, 8'h22);
        rd_chk(5'h00, 8'h22);
        chk_val(16'(n_ab), 16'h1);
        stall = 1'b0;
        // no new dma command follows the abort
        wait_idle();
        // start stays set when stop is written
        wr(5'h00, 8'h21);
        rd_chk(5'h00, 8'h23);
        chk_val({15'h0, halted}, 16'h1);
        wr(5'h00, 8'h22);
        chk_val({14'h0, run_active, halted}, 16'h2);
        // three outcomes of a transmission
        for (int k = 0; k < 3; k++) begin
            res_in = RES_TAB[k];
            wr(5'h00, 8'h26);
            rd_chk(5'h00, 8'h26);
            chk_val(16'(n_tx), 16'(k + 1));
            rd_chk(5'h05, 8'h00);
            wait_idle();
            rd_chk(5'h04, {res_in.late_clash_flag, 3'b000, res_in.tx_gave_up_flag,
                res_in.collided, 1'b0, res_in.tx_ok_flag});
            rd_chk(5'h05, (res_in.tx_gave_up_flag || !res_in.collided) ? 8'h00 :
                {4'h0, res_in.retry_tally});
            rd_chk(5'h00, 8'h22);
        end
        // pages 1..3 hide the page 0 registers
        for (int p = 1; p < 4; p++) begin
            wr(5'h00, {2'(p), 6'h22});
            chk_val({14'h0, page_select_bits}, 16'(p));
            rd_chk(5'h00, {2'(p), 6'h22});
            wr(5'h01, 8'hFF);
            rd_chk(5'h01, 8'h00);
        end
        pulse(1'b1);
        rd_chk(5'h00, 8'h23);
        rd_chk(5'h01, 8'h3A);
        pulse(1'b0);
        rd_chk(5'h00, 8'h21);
        chk_val({14'h0, run_active, halted}, 16'h1);
        chk_val(16'(n_ab), 16'h1);
        complete_run();
    end
endmodule : mct_cmd_tx_regs_bench
